//--- dcpfl_map.vh
`ifndef DCPFL_MAP_VH
`define DCPFL_MAP_VH
// Register byte offsets.
`define DCPFL_CTRL 12'h000
`define DCPFL_STATUS 12'h004
`define DCPFL_IRQ_STAT 12'h008
`define DCPFL_IRQ_MASK 12'h00c
`define DCPFL_OVERRIDE 12'h010
`define DCPFL_LQ_LIMIT 12'h014
`define DCPFL_REC_ID 12'h018
`define DCPFL_REC_LIMIT 12'h01c
`define DCPFL_REC_TIME 12'h020
`define DCPFL_PASSWORD 12'h024
`define DCPFL_ROUTE_BASE 12'h040
`define DCPFL_LIM_S_BASE 12'h080
`define DCPFL_LIM_P_BASE 12'h0c0
// Sizes.
`define DCPFL_NUM_LQ 16
`define DCPFL_LQ_W 4
`define DCPFL_NUM_CH 4
// Control bit positions.
`define DCPFL_CTRL_SW_RESET 0
`define DCPFL_CTRL_SELF_FAIL 1
// Interrupt bit positions.
`define DCPFL_IRQ_LQ 0
`define DCPFL_IRQ_SELF 1
`define DCPFL_IRQ_DUTY 2
`define DCPFL_IRQ_RESET 3
// Reset values.
`define DCPFL_ROUTE_RST 4'hf
`define DCPFL_LIMIT_RST 32'hffffffff
`define DCPFL_PASSWORD_RST 32'h00000000
// Time step: 1 ms at 25 ns period.
`define DCPFL_STEP_NS 1000000
`define DCPFL_CLK_NS 25
`define DCPFL_STEP_CYC (`DCPFL_STEP_NS / `DCPFL_CLK_NS)
`endif

//--- dcpfl_lq_mem.v
`timescale 1ns/100ps
`include "dcpfl_map.vh"
// Small table of per limit quantity words with registered read data.
module dcpfl_lq_mem (
   input wire mclk,
   input wire we,
   input wire [3:0] waddr,
   input wire [31:0] wdata,
   input wire [3:0] raddr,
   output reg [31:0] rdata
);
   reg [31:0] mem [0:`DCPFL_NUM_LQ-1];

   // Write and registered read; contents are loaded by software after reset.
   always @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

//--- dcpfl_fault_latch.v
`timescale 1ns/100ps
`include "dcpfl_map.vh"
// Operation
// - Finish pulse, then block pulse until reset.
// - Over limit faults routed channels.
// - Four channels: toroidal, solenoid, two poloidal.
// - Per quantity adjustable channel selection.
// - Selected lines latched until reset.
// - Record quantity, limit and time.
// - Self failure sets all four channels.
// - Duty violation sets all four channels.
// - Software reset needs key, password; standby.
// - Hardware reset only from local key.
// - Each channel: short, open, status outputs.
// - Keyed override suppresses any channel subset.
// - Fault record leaves on one-way link.
// - Raw inputs stream out one way.
// - Maintenance activity forces all lines faulted.
// - Standby uses standby limit; pulse both.
module dcpfl_fault_latch (
   input wire mclk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [3:0] lq_sel,
   input wire [31:0] lq_present,
   input wire [31:0] lq_predicted,
   input wire lq_valid,
   input wire pulse_start_trig,
   input wire standby_trig,
   input wire duty_violation,
   input wire self_fail_in,
   input wire sw_key,
   input wire hw_reset_key,
   input wire hw_reset_btn,
   input wire test_key,
   input wire maint_active,
   input wire [31:0] raw_inputs,
   output reg pulse_phase,
   output reg pulse_inhibit,
   output wire [3:0] fault_short,
   output wire [3:0] fault_short_oe,
   output wire [3:0] fault_open,
   output wire [3:0] fault_open_oe,
   output wire [3:0] fault_status,
   output wire [3:0] fault_status_oe,
   output reg rec_tx_valid,
   output reg [31:0] rec_tx_data,
   output reg daq_tx_valid,
   output reg [31:0] daq_tx_data,
   output wire irq
);
   localparam S_IDLE = 2'd0;
   localparam S_RD_S = 2'd1;
   localparam S_RD_P = 2'd2;
   localparam S_CMP = 2'd3;

   reg [1:0] cmp_state;
   reg [3:0] latch;
   reg [3:0] override;
   reg [3:0] route [0:`DCPFL_NUM_LQ-1];
   reg [31:0] password;
   reg [31:0] rec_id;
   reg [31:0] rec_limit;
   reg [31:0] rec_time;
   reg [31:0] time_ctr;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   reg [31:0] step_ctr;
   reg [3:0] cur_sel;
   reg [31:0] cur_pres;
   reg [31:0] cur_pred;
   reg [31:0] cur_lim_s;
   reg [1:0] tx_idx;
   reg tx_busy;
   reg sw_ok_q;
   reg [3:0] rd_idx;
   reg next_trip_q;

   wire wr = psel & penable & pwrite;
   wire [31:0] mem_rd;
   wire in_pulse_tab = {paddr[11:6], 6'h00} == `DCPFL_LIM_P_BASE;
   wire in_stby_tab = {paddr[11:6], 6'h00} == `DCPFL_LIM_S_BASE;
   wire mem_we_s = wr & in_stby_tab;
   wire mem_we_p = wr & in_pulse_tab;
   wire [31:0] lim_s_rd;
   wire [31:0] lim_p_rd;

   // Table lookups run either for the comparator or for a bus read.
   wire cmp_busy = cmp_state != S_IDLE;
   wire [3:0] tab_raddr = cmp_busy ? cur_sel : paddr[5:2];

   dcpfl_lq_mem u_lim_s (
      .mclk(mclk),
      .we(mem_we_s),
      .waddr(paddr[5:2]),
      .wdata(pwdata),
      .raddr(tab_raddr),
      .rdata(lim_s_rd)
   );

   dcpfl_lq_mem u_lim_p (
      .mclk(mclk),
      .we(mem_we_p),
      .waddr(paddr[5:2]),
      .wdata(pwdata),
      .raddr(tab_raddr),
      .rdata(lim_p_rd)
   );

   assign mem_rd = in_pulse_tab ? lim_p_rd : lim_s_rd;

   // The table read needs one extra cycle, so table reads wait a cycle.
   reg tab_wait;
   assign pready = ~((in_pulse_tab | in_stby_tab) & ~pwrite & ~tab_wait);
   assign pslverr = 1'b0;

   // Reset validation: software needs key plus password, hardware a local key.
   wire sw_reset_req = wr && paddr == `DCPFL_CTRL &&
      pwdata[`DCPFL_CTRL_SW_RESET];
   wire sw_reset_ok = sw_reset_req & sw_key &
      (password == `DCPFL_PASSWORD_RST ? 1'b0 : 1'b1) & sw_ok_q;
   wire hw_reset_ok = hw_reset_key & hw_reset_btn;
   wire fault_reset = sw_reset_ok | hw_reset_ok;

   // Global faults: self failure and duty cycle violation.
   wire self_fail = self_fail_in | (wr && paddr == `DCPFL_CTRL &&
      pwdata[`DCPFL_CTRL_SELF_FAIL]);

   // Limit compare; standby uses present only, pulse uses both.
   wire over_s = cur_pres > cur_lim_s;
   wire over_p = cur_pres > lim_p_rd || cur_pred > lim_p_rd;
   wire lq_trip = (cmp_state == S_CMP) &&
      (pulse_phase ? over_p : over_s);
   wire [3:0] trip_ch = route[cur_sel];
   wire [3:0] set_ch = (lq_trip ? trip_ch : 4'h0) |
      ((self_fail | duty_violation) ? 4'hf : 4'h0);

   // Password must have been written before a software reset will be honoured.
   always @(posedge mclk) begin
      if (sys_rst) begin
         sw_ok_q <= 1'b0;
      end else if (wr && paddr == `DCPFL_PASSWORD) begin
         sw_ok_q <= 1'b1;
      end else if (sw_reset_req) begin
         sw_ok_q <= 1'b0;
      end
   end

   // Comparator sequence: capture sample, read both limits, compare.
   always @(posedge mclk) begin
      if (sys_rst) begin
         cmp_state <= S_IDLE;
         cur_sel <= 4'h0;
         cur_pres <= 32'h00000000;
         cur_pred <= 32'h00000000;
         cur_lim_s <= 32'h00000000;
      end else begin
         case (cmp_state)
            S_IDLE: begin
               if (lq_valid) begin
                  cur_sel <= lq_sel;
                  cur_pres <= lq_present;
                  cur_pred <= lq_predicted;
                  cmp_state <= S_RD_S;
               end
            end
            S_RD_S: cmp_state <= S_RD_P;
            S_RD_P: begin
               cur_lim_s <= lim_s_rd;
               cmp_state <= S_CMP;
            end
            S_CMP: cmp_state <= S_IDLE;
            default: cmp_state <= S_IDLE;
         endcase
      end
   end

   // Fault latches; a new fault wins over a reset in the same cycle.
   always @(posedge mclk) begin
      if (sys_rst) begin
         latch <= 4'h0;
      end else begin
         latch <= (fault_reset ? 4'h0 : latch) | set_ch;
      end
   end

   // Pulse phase control: a fault lets the pulse finish but blocks the next.
   always @(posedge mclk) begin
      if (sys_rst) begin
         pulse_phase <= 1'b0;
         pulse_inhibit <= 1'b0;
      end else begin
         if (sw_reset_ok || standby_trig) begin
            pulse_phase <= 1'b0;
         end else if (pulse_start_trig && !pulse_inhibit && set_ch == 4'h0) begin
            pulse_phase <= 1'b1;
         end
         if (set_ch != 4'h0) begin
            pulse_inhibit <= 1'b1;
         end else if (fault_reset) begin
            pulse_inhibit <= 1'b0;
         end
      end
   end

   // Time base ticks each protection step and stamps fault records.
   always @(posedge mclk) begin
      if (sys_rst) begin
         step_ctr <= 32'h00000000;
         time_ctr <= 32'h00000000;
      end else if (step_ctr == `DCPFL_STEP_CYC - 1) begin
         step_ctr <= 32'h00000000;
         time_ctr <= time_ctr + 32'h00000001;
      end else begin
         step_ctr <= step_ctr + 32'h00000001;
      end
   end

   // Fault record survives fault resets; only a new trip or sys_rst overwrites it.
   always @(posedge mclk) begin
      if (sys_rst) begin
         rec_id <= 32'h00000000;
         rec_limit <= 32'h00000000;
         rec_time <= 32'h00000000;
         next_trip_q <= 1'b0;
      end else begin
         next_trip_q <= lq_trip;
         if (lq_trip) begin
            rec_id <= {28'h0000000, cur_sel};
            rec_limit <= pulse_phase ? lim_p_rd : cur_lim_s;
            rec_time <= time_ctr;
         end
      end
   end

   // One-way record export: id, limit, time as three words.
   always @(posedge mclk) begin
      if (sys_rst) begin
         tx_busy <= 1'b0;
         tx_idx <= 2'd0;
         rec_tx_valid <= 1'b0;
         rec_tx_data <= 32'h00000000;
      end else begin
         rec_tx_valid <= 1'b0;
         if (next_trip_q && !tx_busy) begin
            tx_busy <= 1'b1;
            tx_idx <= 2'd0;
         end else if (tx_busy) begin
            rec_tx_valid <= 1'b1;
            case (tx_idx)
               2'd0: rec_tx_data <= rec_id;
               2'd1: rec_tx_data <= rec_limit;
               default: rec_tx_data <= rec_time;
            endcase
            tx_idx <= tx_idx + 2'd1;
            if (tx_idx == 2'd2) begin
               tx_busy <= 1'b0;
            end
         end
      end
   end

   // Raw inputs stream to acquisition once per time step.
   always @(posedge mclk) begin
      if (sys_rst) begin
         daq_tx_valid <= 1'b0;
         daq_tx_data <= 32'h00000000;
      end else begin
         daq_tx_valid <= step_ctr == 32'h00000000;
         if (step_ctr == 32'h00000000) begin
            daq_tx_data <= raw_inputs;
         end
      end
   end

   // Register writes; override bits only take effect under the test key.
   integer i;
   always @(posedge mclk) begin
      if (sys_rst) begin
         override <= 4'h0;
         irq_mask <= 4'h0;
         password <= `DCPFL_PASSWORD_RST;
         for (i = 0; i < `DCPFL_NUM_LQ; i = i + 1) begin
            route[i] <= `DCPFL_ROUTE_RST;
         end
      end else if (wr) begin
         if (paddr == `DCPFL_OVERRIDE) begin
            override <= pwdata[3:0];
         end
         if (paddr == `DCPFL_IRQ_MASK) begin
            irq_mask <= pwdata[3:0];
         end
         if (paddr == `DCPFL_PASSWORD) begin
            password <= pwdata;
         end
         if ({paddr[11:6], 6'h00} == `DCPFL_ROUTE_BASE) begin
            route[paddr[5:2]] <= pwdata[3:0];
         end
      end
   end

   // Sticky interrupt status; a new event wins over write-one-to-clear.
   wire [3:0] irq_ev = {fault_reset, duty_violation, self_fail, lq_trip};
   always @(posedge mclk) begin
      if (sys_rst) begin
         irq_stat <= 4'h0;
      end else if (wr && paddr == `DCPFL_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~pwdata[3:0]) | irq_ev;
      end else begin
         irq_stat <= irq_stat | irq_ev;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // Read mux; table reads return data from the limit memories.
   always @(posedge mclk) begin
      if (sys_rst) begin
         tab_wait <= 1'b0;
      end else begin
         tab_wait <= psel & ~tab_wait & (in_pulse_tab | in_stby_tab);
      end
   end

   always @* begin
      rd_idx = paddr[5:2];
      prdata = 32'h00000000;
      case (paddr)
         `DCPFL_STATUS: prdata = {24'h000000, pulse_inhibit, pulse_phase,
            2'b00, latch};
         `DCPFL_IRQ_STAT: prdata = {28'h0000000, irq_stat};
         `DCPFL_IRQ_MASK: prdata = {28'h0000000, irq_mask};
         `DCPFL_OVERRIDE: prdata = {28'h0000000, override};
         `DCPFL_REC_ID: prdata = rec_id;
         `DCPFL_REC_LIMIT: prdata = rec_limit;
         `DCPFL_REC_TIME: prdata = rec_time;
         default: begin
            if ({paddr[11:6], 6'h00} == `DCPFL_ROUTE_BASE) begin
               prdata = {28'h0000000, route[rd_idx]};
            end else if (in_pulse_tab | in_stby_tab) begin
               prdata = mem_rd;
            end
         end
      endcase
   end

   // Output stage per channel: channels are toroidal, solenoid, two poloidal.
   // Maintenance forcing beats the override so the plant is never left live.
   genvar g;
   generate
      for (g = 0; g < `DCPFL_NUM_CH; g = g + 1) begin : g_ch
         wire act = maint_active |
            (latch[g] & ~(test_key & override[g]));
         // Open collectors sink current only while faulted.
         assign fault_short[g] = 1'b0;
         assign fault_short_oe[g] = act;
         assign fault_open[g] = 1'b0;
         assign fault_open_oe[g] = act;
         assign fault_status[g] = 1'b0;
         assign fault_status_oe[g] = act;
      end
   endgenerate
endmodule

//--- dcpfl_asserts.sv
`timescale 1ns/100ps
// Watches the fault lines, phase outputs and export strobes at the ports.
module dcpfl_asserts (
   input wire mclk,
   input wire sys_rst,
   input wire psel,
   input wire pwrite,
   input wire self_fail_in,
   input wire duty_violation,
   input wire test_key,
   input wire maint_active,
   input wire hw_reset_key,
   input wire hw_reset_btn,
   input wire standby_trig,
   input wire pulse_phase,
   input wire pulse_inhibit,
   input wire [3:0] fault_short,
   input wire [3:0] fault_short_oe,
   input wire [3:0] fault_open_oe,
   input wire [3:0] fault_status_oe,
   input wire rec_tx_valid,
   input wire daq_tx_valid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // A quiet cycle has neither the override key nor maintenance active.
   wire quiet = !test_key && !maint_active;
   wire hw_rst = hw_reset_key && hw_reset_btn;
   wire no_src = !self_fail_in && !duty_violation && !psel;

   a_maint_all: assert property (
      maint_active |-> fault_short_oe == 4'hf)
      else $error("maintenance left a line unfaulted");
   a_self_all: assert property (
      self_fail_in && quiet ##1 quiet |-> ##[0:1] fault_open_oe == 4'hf)
      else $error("self failure did not fault all lines");
   a_duty_all: assert property (
      duty_violation && quiet ##1 quiet |-> ##[0:1] fault_status_oe == 4'hf)
      else $error("duty violation did not fault all lines");
   a_lines_agree: assert property (
      fault_short_oe == fault_open_oe && fault_open_oe == fault_status_oe
      && fault_short == 4'h0)
      else $error("fault outputs of a channel disagree");
   // Without a valid reset a latched line may only gain faults.
   a_latch_hold: assert property (
      quiet && !hw_rst && !(psel && pwrite) ##1 quiet |->
      (fault_status_oe & $past(fault_status_oe)) == $past(fault_status_oe))
      else $error("latched fault line dropped without reset");
   a_hw_clears: assert property (
      hw_rst && no_src ##1 quiet && no_src |->
      fault_status_oe == 4'h0 && !pulse_inhibit)
      else $error("keyed reset did not clear the latch");
   a_inhibit_hold: assert property (
      pulse_inhibit && !pulse_phase |=> !pulse_phase)
      else $error("pulse started while inhibited");
   a_pulse_runs: assert property (
      pulse_phase && !standby_trig && !hw_rst && !(psel && pwrite)
      |=> pulse_phase)
      else $error("pulse ended without standby request");
   a_rec_three: assert property (
      $rose(rec_tx_valid) |-> rec_tx_valid [*3])
      else $error("fault record shorter than three words");
   a_daq_pulse: assert property (
      daq_tx_valid |=> !daq_tx_valid)
      else $error("sample strobe longer than one cycle");
   c_trip: cover property ($rose(rec_tx_valid));
   c_inhibit: cover property ($rose(pulse_inhibit));
   c_daq: cover property (daq_tx_valid);
endmodule
bind dcpfl_fault_latch dcpfl_asserts u_chk (.mclk, .sys_rst, .psel, .pwrite,
   .self_fail_in, .duty_violation, .test_key, .maint_active, .hw_reset_key,
   .hw_reset_btn, .standby_trig, .pulse_phase, .pulse_inhibit, .fault_short,
   .fault_short_oe, .fault_open_oe, .fault_status_oe, .rec_tx_valid,
   .daq_tx_valid);

//--- dcpfl_board_model.sv
`timescale 1ns/100ps
// Supply control boards: each fault line is pulled up on the board, so a
// released output reads high and a sinking output pulls the line low.
module dcpfl_board_model (
   input wire [3:0] short_oe,
   input wire [3:0] open_oe,
   input wire [3:0] status_oe,
   output wire [3:0] par_line,
   output wire [3:0] ser_line,
   output wire [3:0] st_line
);
   // Low parallel line is a shorted loop, low series line an opened one.
   assign par_line = ~short_oe;
   assign ser_line = ~open_oe;
   assign st_line = ~status_oe;
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
`include "dcpfl_map.vh"
module tb_top;
   logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, lq_present = 0, lq_predicted = 0, raw_inputs = 0;
   logic [3:0] lq_sel = 0, r, o = 0, s;
   logic lq_valid = 0, pulse_start_trig = 0, standby_trig = 0;
   logic duty_violation = 0, self_fail_in = 0, sw_key = 0, test_key = 0;
   logic hw_reset_key = 0, hw_reset_btn = 0, maint_active = 0;
   logic [31:0] q, lim;
   logic [31:0] rx [0:2];
   logic pe;
   int rx_n = 0;
   wire [31:0] prdata, rec_tx_data, daq_tx_data;
   wire pready, pslverr, pulse_phase, pulse_inhibit, rec_tx_valid;
   wire daq_tx_valid, irq;
   wire [3:0] fault_short, fault_short_oe, fault_open, fault_open_oe;
   wire [3:0] fault_status, fault_status_oe, par_line, ser_line, st_line;
   int err_total = 0, samples_checked = 0;
   integer seed = 32'hb8dd41e6;

   // Free-running 40 MHz clock.
   always #12.5 mclk = ~mclk;

   dcpfl_fault_latch dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .lq_sel, .lq_present,
      .lq_predicted, .lq_valid, .pulse_start_trig, .standby_trig,
      .duty_violation, .self_fail_in, .sw_key, .hw_reset_key, .hw_reset_btn,
      .test_key, .maint_active, .raw_inputs, .pulse_phase, .pulse_inhibit,
      .fault_short, .fault_short_oe, .fault_open, .fault_open_oe,
      .fault_status, .fault_status_oe, .rec_tx_valid, .rec_tx_data,
      .daq_tx_valid, .daq_tx_data, .irq);
   dcpfl_board_model boards (.short_oe(fault_short_oe),
      .open_oe(fault_open_oe), .status_oe(fault_status_oe), .par_line,
      .ser_line, .st_line);

   // Collects the exported record words; each record is three words long.
   always @(posedge mclk) begin
      if (rec_tx_valid === 1'b1) begin
         rx[rx_n % 3] <= rec_tx_data;
         rx_n <= rx_n + 1;
      end
   end

   task give_verdict;
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
      chk({31'h0, pe}, 32'h0);
   endtask

   // Maintenance forces every line, a keyed override masks its bits.
   function logic [3:0] seen(input logic [3:0] l);
      if (maint_active)
         return 4'hf;
      return test_key ? l & ~o : l;
   endfunction

   // Checks the sink pattern and the board lines midway through a cycle.
   task lines(input logic [3:0] l);
      @(posedge mclk);
      @(negedge mclk);
      chk({fault_short_oe, fault_open_oe, ~par_line, ~ser_line, ~st_line},
         {5{seen(l)}});
      chk({fault_short, fault_open, fault_status}, 32'h0);
      @(posedge mclk);
   endtask

   task sample(input logic [31:0] pres, input logic [31:0] pred);
      lq_present <= pres;
      lq_predicted <= pred;
      lq_valid <= 1'b1;
      @(posedge mclk);
      lq_valid <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask

   // Sanity limit so a stuck handshake still ends the run.
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      give_verdict;
   end

   initial begin
      integer k, v;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      raw_inputs <= $random(seed);
      rdc(`DCPFL_ROUTE_BASE + 12'h03c, 32'hf);
      rdc(`DCPFL_STATUS, 32'h0);
      rdc(12'h300, 32'h0);
      // Step one quantity across its limit, in standby then in a pulse.
      for (k = 0; k < 2; k++) begin
         s = 4'($random(seed));
         lq_sel <= s;
         r = 4'($random(seed)) | 4'h1;
         lim = {16'h0, 16'($random(seed))} + 32'h2;
         apb(1'b1, `DCPFL_ROUTE_BASE + {6'h0, s, 2'b0}, {28'h0, r});
         apb(1'b1, `DCPFL_LIM_S_BASE + {6'h0, s, 2'b0}, lim);
         apb(1'b1, `DCPFL_LIM_P_BASE + {6'h0, s, 2'b0}, lim + 100);
         pulse_start_trig <= k[0];
         @(posedge mclk);
         pulse_start_trig <= 1'b0;
         for (v = -1; v < 2; v++) begin
            if (k) sample(lim, lim + 100 + v);
            else sample(lim + v, 32'h0);
            lines(v == 1 ? r : 4'h0);
         end
         chk(rx[0], {28'h0, s});
         chk(rx[1], k ? lim + 100 : lim);
         chk(rx[2], 32'h0);
         rdc(`DCPFL_REC_ID, {28'h0, s});
         rdc(`DCPFL_REC_LIMIT, k ? lim + 100 : lim);
         rdc(`DCPFL_STATUS, {24'h0, 1'b1, k[0], 2'b00, r});
         standby_trig <= 1'b1;
         @(posedge mclk);
         standby_trig <= 1'b0;
         pulse_start_trig <= 1'b1;
         @(posedge mclk);
         pulse_start_trig <= 1'b0;
         lines(r);
         chk({31'h0, pulse_phase}, 32'h0);
         hw_reset_btn <= 1'b1;
         lines(r);
         hw_reset_key <= 1'b1;
         lines(4'h0);
         hw_reset_key <= 1'b0;
         hw_reset_btn <= 1'b0;
         chk({31'h0, pulse_inhibit}, 32'h0);
         rdc(`DCPFL_REC_ID, {28'h0, lq_sel});
      end
      self_fail_in <= 1'b1;
      @(posedge mclk);
      self_fail_in <= 1'b0;
      lines(4'hf);
      o = 4'($random(seed));
      apb(1'b1, `DCPFL_OVERRIDE, {28'h0, o});
      test_key <= 1'b1;
      lines(4'hf);
      maint_active <= 1'b1;
      lines(4'hf);
      maint_active <= 1'b0;
      test_key <= 1'b0;
      // Interrupt: trips, resets and the self failure are pending.
      apb(1'b1, `DCPFL_IRQ_MASK, 32'h0);
      rdc(`DCPFL_IRQ_STAT, 32'hb);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `DCPFL_IRQ_MASK, 32'h2);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `DCPFL_IRQ_STAT, 32'h2);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `DCPFL_PASSWORD, $random(seed) | 32'h1);
      apb(1'b1, `DCPFL_CTRL, 32'h1);
      lines(4'hf);
      sw_key <= 1'b1;
      // A refused attempt uses up the password, so it is written again.
      apb(1'b1, `DCPFL_PASSWORD, $random(seed) | 32'h1);
      apb(1'b1, `DCPFL_CTRL, 32'h1);
      lines(4'h0);
      sw_key <= 1'b0;
      duty_violation <= 1'b1;
      @(posedge mclk);
      duty_violation <= 1'b0;
      lines(4'hf);
      hw_reset_key <= 1'b1;
      hw_reset_btn <= 1'b1;
      lines(4'h0);
      hw_reset_key <= 1'b0;
      hw_reset_btn <= 1'b0;
      apb(1'b1, `DCPFL_CTRL, 32'h2);
      lines(4'hf);
      // A fresh input word must reach acquisition at the next step.
      raw_inputs <= $random(seed);
      for (k = 0; k < 41000 && daq_tx_valid !== 1'b1; k++) @(posedge mclk);
      chk({31'h0, daq_tx_valid}, 32'h1);
      chk(daq_tx_data, raw_inputs);
      give_verdict;
   end
endmodule
